//--- rtl/amsc_consts.svh
// Constants for the converter configuration word decoder
// Functional notes
// (R1) Header 101 loads channel then speed fields
// (R2) Header 000 or 100 keeps previous settings
// (R3) Power-up: pair 0/1, paired reference, 256, 1x
// (R4) Differential pair from address, slaved reference
// (R5) Odd bit swaps differential polarity
// (R6) Single-ended: channel 2*addr+odd against common
// (R7) Global bit selects fifth reference pair
// (R8) Zero oversampling code keeps previous speed
// (R9) Codes 1-9 give 64..16384, code 15 32768
// (R10) Last speed bit selects 1x or 2x
// (R11) 1x combines two conversions, cancelling offset
// (R12) 1x results always valid, no latency
// (R13) 2x result averages last two conversions
// (R14) 2x first result after channel change invalid
// (R15) 2x speed-only change: first result valid
// (R16) Mode-only change leaves first result valid
// (R17) 2x switches multiplexer at conversion end
// (R18) 1x switches multiplexer at 14th falling edge; a 2x conversion end in that cycle wins and the 14th-edge switch is skipped
// (R19) Undefined oversampling codes keep previous speed
`ifndef AMSC_CONSTS_SVH
`define AMSC_CONSTS_SVH

`define AMSC_WORD_BITS 13
`define AMSC_HDR_UPDATE 3'h5
`define AMSC_MUX_SWITCH_FALL 6'h0E
`define AMSC_WORD_DONE_RISE 6'h0D

// Channel field positions inside the 5-bit channel word
`define AMSC_CH_SGL 4
`define AMSC_CH_ODD 3
`define AMSC_CH_GLOBAL_REFERENCE_SELECT 2

// Power-up selection
`define AMSC_RST_CHAN 5'h00
`define AMSC_RST_OSR 4'h3
`define AMSC_RST_RATE_DOUBLER_SELECT 1'b0

`define AMSC_COM_INDEX 4'h8
`define AMSC_GLOBAL_REF 3'h4
`define AMSC_OSR_MAX_LINEAR 4'h9
`define AMSC_OSR_TOP 4'hF
`define AMSC_OSR_BASE_LOG2 4'h5

// APB register map
`define AMSC_ADDR_CTRL 12'h000
`define AMSC_ADDR_STATUS 12'h004
`define AMSC_ADDR_MUX 12'h008
`define AMSC_CTRL_RST 32'h00000001

`endif

//--- rtl/amsc_pkg.sv
// Types shared by the configuration decoder
package amsc_pkg;
	typedef logic [4:0] amsc_chan_t;
	typedef logic [3:0] amsc_osr_t;
endpackage

//--- rtl/amsc_link_sync.sv
// Synchronisers and edge finder for the serial link pins
module amsc_link_sync
	import amsc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Pins
	input wire logic serialClk,
	input wire logic serialIn,
	input wire logic chipSelN,
	// Synchronised view
	output logic serialClkRise,
	output logic serialClkFall,
	output logic serialInLevel,
	output logic chipSelNLevel,
	output logic chipSelRise
);
	logic [2:0] pinRaw;
	logic [2:0] stageA;
	logic [2:0] stageB;
	logic clkLast;
	logic csnLast;

	assign pinRaw = {chipSelN, serialIn, serialClk};

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : gSync
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					stageA[i] <= (i == 2) ? 1'b1 : 1'b0;
					stageB[i] <= (i == 2) ? 1'b1 : 1'b0;
				end else begin
					stageA[i] <= pinRaw[i];
					stageB[i] <= stageA[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			clkLast <= 1'b0;
			csnLast <= 1'b1;
		end else begin
			clkLast <= stageB[0];
			csnLast <= stageB[2];
		end
	end

	assign serialClkRise = stageB[0] & ~clkLast;
	assign serialClkFall = ~stageB[0] & clkLast;
	assign serialInLevel = stageB[1];
	assign chipSelNLevel = stageB[2];
	assign chipSelRise = stageB[2] & ~csnLast;
endmodule

//--- rtl/amsc_decoder.sv
// Configuration word decoder with multiplexer timing and result validity
`include "amsc_consts.svh"
module amsc_decoder
	import amsc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link pins
	input wire logic serialClk,
	input wire logic serialIn,
	input wire logic chipSelN,
	// Converter core
	input wire logic convEnd,
	output logic resultStrobe,
	output logic resultValid,
	output logic mixedNoise,
	output logic offsetCancel,
	output logic runningAverage,
	// Analog selection
	output logic [3:0] muxPos,
	output logic [3:0] muxNeg,
	output logic [2:0] refSel,
	output logic [15:0] oversamplingRatio,
	output logic rateDoublerSelect
);
	logic serialClkRise;
	logic serialClkFall;
	logic serialInLevel;
	logic chipSelNLevel;
	logic chipSelRise;

	amsc_link_sync uSync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.serialClk(serialClk),
		.serialIn(serialIn),
		.chipSelN(chipSelN),
		.serialClkRise(serialClkRise),
		.serialClkFall(serialClkFall),
		.serialInLevel(serialInLevel),
		.chipSelNLevel(chipSelNLevel),
		.chipSelRise(chipSelRise)
	);

	function automatic logic osrKnown(input amsc_osr_t code);
		osrKnown = (code != 4'h0) &&
			((code <= `AMSC_OSR_MAX_LINEAR) || (code == `AMSC_OSR_TOP));
	endfunction

	function automatic logic [3:0] posOf(input amsc_chan_t ch);
		if (ch[`AMSC_CH_SGL])
			posOf = {1'b0, ch[1:0], ch[`AMSC_CH_ODD]};
		else
			posOf = {1'b0, ch[1:0], ch[`AMSC_CH_ODD]};
	endfunction

	function automatic logic [3:0] negOf(input amsc_chan_t ch);
		if (ch[`AMSC_CH_SGL])
			negOf = `AMSC_COM_INDEX;
		else
			negOf = {1'b0, ch[1:0], ~ch[`AMSC_CH_ODD]};
	endfunction

	// Registers and link state
	logic [31:0] ctrlReg;
	logic [5:0] riseCnt;
	logic [5:0] fallCnt;
	logic [`AMSC_WORD_BITS-1:0] shiftWord;
	logic wordDoneD;
	logic pendValid;
	logic pendSpeed;
	amsc_chan_t pendChan;
	amsc_osr_t pendOsr;
	logic pendTwox;
	amsc_chan_t curChan;
	amsc_osr_t curOsr;
	logic curTwox;
	amsc_chan_t muxChan;
	logic chanFirst;
	logic speedFirst;

	wire linkOn = ctrlReg[0];
	wire inFrame = linkOn && !chipSelNLevel;
	wire wordDone = inFrame && serialClkRise && (riseCnt == `AMSC_WORD_DONE_RISE - 6'h01);
	wire [2:0] hdrBits = shiftWord[12:10];
	wire amsc_chan_t wordChan = shiftWord[9:5];
	wire amsc_osr_t wordOsr = shiftWord[4:1];
	wire wordTwox = shiftWord[0];
	wire hdrUpdate = (hdrBits == `AMSC_HDR_UPDATE);
	wire applyNow = chipSelRise && pendValid && (fallCnt >= `AMSC_MUX_SWITCH_FALL);
	wire chanChange = applyNow && (pendChan != curChan);
	wire speedChange = applyNow && pendSpeed && (pendOsr != curOsr);
	wire muxEarly = inFrame && serialClkFall && (fallCnt == `AMSC_MUX_SWITCH_FALL - 6'h01) &&
		pendValid && !pendTwox && (pendChan != muxChan);
	wire [3:0] ratioLog2 = (curOsr == `AMSC_OSR_TOP) ? 4'hF :
		4'(curOsr + `AMSC_OSR_BASE_LOG2);

	// Frame edge counters and shifter
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			riseCnt <= 6'h00;
			fallCnt <= 6'h00;
			shiftWord <= '0;
			wordDoneD <= 1'b0;
		end else begin
			wordDoneD <= wordDone;
			if (!inFrame) begin
				riseCnt <= 6'h00;
				fallCnt <= 6'h00;
			end else begin
				if (serialClkRise && riseCnt != 6'h3F)
					riseCnt <= riseCnt + 6'h01;
				if (serialClkFall && fallCnt != 6'h3F)
					fallCnt <= fallCnt + 6'h01;
				if (serialClkRise && riseCnt < `AMSC_WORD_DONE_RISE)
					shiftWord <= {shiftWord[`AMSC_WORD_BITS-2:0], serialInLevel};
			end
		end
	end

	// Pending word from the link
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pendValid <= 1'b0;
			pendSpeed <= 1'b0;
			pendChan <= `AMSC_RST_CHAN;
			pendOsr <= `AMSC_RST_OSR;
			pendTwox <= `AMSC_RST_RATE_DOUBLER_SELECT;
		end else if (wordDoneD) begin
			pendValid <= hdrUpdate; // R1 R2
			pendSpeed <= hdrUpdate && osrKnown(wordOsr); // R8 R19
			pendChan <= wordChan;
			pendOsr <= osrKnown(wordOsr) ? wordOsr : curOsr; // R8 R19
			pendTwox <= osrKnown(wordOsr) ? wordTwox : curTwox; // R10
		end else if (chipSelRise) begin
			pendValid <= 1'b0;
		end
	end

	// Applied selection for the next conversion
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			curChan <= `AMSC_RST_CHAN; // R3
			curOsr <= `AMSC_RST_OSR; // R3
			curTwox <= `AMSC_RST_RATE_DOUBLER_SELECT; // R3
		end else if (applyNow) begin
			curChan <= pendChan; // R4 R7
			if (pendSpeed) begin
				curOsr <= pendOsr; // R9
				curTwox <= pendTwox; // R10
			end
		end
	end

	// Multiplexer switching moment
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			muxChan <= `AMSC_RST_CHAN;
		else if (convEnd && curTwox)
			muxChan <= curChan; // R17
		else if (muxEarly)
			muxChan <= pendChan; // R18
	end

	// Validity tracking; a new change wins over the clearing conversion end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			chanFirst <= 1'b0;
			speedFirst <= 1'b0;
			resultStrobe <= 1'b0;
			resultValid <= 1'b0;
			mixedNoise <= 1'b0;
		end else begin
			resultStrobe <= convEnd;
			if (convEnd) begin
				resultValid <= !(curTwox && chanFirst); // R12 R14 R16
				mixedNoise <= curTwox && speedFirst && !chanFirst; // R15
			end
			if (applyNow) begin
				chanFirst <= chanChange;
				speedFirst <= speedChange;
			end else if (convEnd) begin
				chanFirst <= 1'b0;
				speedFirst <= 1'b0;
			end
		end
	end

	assign muxPos = posOf(muxChan); // R4 R5 R6
	assign muxNeg = negOf(muxChan); // R5 R6
	assign refSel = muxChan[`AMSC_CH_GLOBAL_REFERENCE_SELECT] ? `AMSC_GLOBAL_REF : {1'b0, muxChan[1:0]}; // R7
	assign oversamplingRatio = 16'(17'h00001 << ratioLog2); // R9
	assign rateDoublerSelect = curTwox; // R10
	assign offsetCancel = !curTwox; // R11
	assign runningAverage = curTwox; // R13

	// APB slave, no wait states
	wire apbSetup = psel && !penable;
	wire apbAccess = psel && penable;
	wire hitCtrl = (paddr == `AMSC_ADDR_CTRL);
	wire hitStatus = (paddr == `AMSC_ADDR_STATUS);
	wire hitMux = (paddr == `AMSC_ADDR_MUX);
	wire hitAny = hitCtrl || hitStatus || hitMux;
	wire [31:0] statusWord = {21'h000000, pendValid, curTwox, curOsr, curChan};
	wire [31:0] muxWord = {21'h000000, refSel, muxNeg, muxPos};
	wire [31:0] readMux = hitCtrl ? ctrlReg : hitStatus ? statusWord :
		hitMux ? muxWord : 32'h00000000;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrlReg <= `AMSC_CTRL_RST;
			prdata <= 32'h00000000;
		end else begin
			if (apbSetup && !pwrite)
				prdata <= readMux;
			if (apbAccess && pwrite && hitCtrl)
				ctrlReg <= {31'h00000000, pwdata[0]};
		end
	end

	assign pready = 1'b1;
	assign pslverr = apbAccess && !hitAny;

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence updWord;
		wordDoneD && hdrUpdate;
	endsequence

	hdr_accept_a: assert property (updWord |=> pendValid) // R1
		else $error("update header not accepted");
	hdr_ignore_a: assert property (wordDoneD && !hdrUpdate |=> !pendValid) // R2
		else $error("ignore header loaded a word");
	pwr_default_a: assert property ($rose(resetn) |-> curChan == `AMSC_RST_CHAN && // R3
		curOsr == `AMSC_RST_OSR && !curTwox)
		else $error("power-up selection wrong");
	diff_pair_a: assert property (!muxChan[`AMSC_CH_SGL] |-> // R4
		muxPos[2:1] == muxChan[1:0] && muxNeg[2:1] == muxChan[1:0] && muxPos != muxNeg)
		else $error("differential pair wrong");
	diff_sign_a: assert property (!muxChan[`AMSC_CH_SGL] |-> // R5
		muxPos[0] == muxChan[`AMSC_CH_ODD])
		else $error("differential polarity wrong");
	se_chan_a: assert property (muxChan[`AMSC_CH_SGL] |-> muxNeg == `AMSC_COM_INDEX && // R6
		muxPos == {1'b0, muxChan[1:0], muxChan[`AMSC_CH_ODD]})
		else $error("single-ended channel wrong");
	global_reference_select_ref_a: assert property (muxChan[`AMSC_CH_GLOBAL_REFERENCE_SELECT] |-> refSel == `AMSC_GLOBAL_REF) // R7
		else $error("global reference not selected");
	osr_keep_a: assert property ((updWord and !osrKnown(wordOsr)) |=> !pendSpeed) // R8
		else $error("speed taken from bad code");
	osr_undef_a: assert property ((updWord and (wordOsr > 4'h9 && wordOsr < 4'hF)) |=> // R19
		!pendSpeed)
		else $error("undefined code accepted");
	ratio_low_a: assert property (curOsr == 4'h1 |-> oversamplingRatio == 16'h0040) // R9
		else $error("ratio for code 1 wrong");
	onex_valid_a: assert property (convEnd && !curTwox |=> resultStrobe && resultValid) // R12
		else $error("1x result not valid");
	rate_doubler_select_first_a: assert property (convEnd && curTwox && chanFirst |=> !resultValid) // R14
		else $error("2x first result after change valid");
	rate_doubler_select_speed_a: assert property (convEnd && curTwox && !chanFirst |=> resultValid) // R15
		else $error("2x speed change marked invalid");
	mux_end2x_a: assert property (convEnd && curTwox |=> muxChan == $past(curChan)) // R17
		else $error("2x mux not switched at end");
	mux_fall14_a: assert property (muxEarly && !(convEnd && curTwox) |=> // R18
		muxChan == $past(pendChan))
		else $error("1x mux not switched on edge 14");
endmodule

//--- tb/amsc_link_host.sv
// Host model driving the serial configuration link
module amsc_link_host (
	// Link pins
	output logic serialClk,
	output logic serialIn,
	output logic chipSelN
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		serialClk = 1'b0;
		serialIn = 1'b0;
		chipSelN = 1'b1;
	end
	// Word MSB first, then idle bits up to nFalls falling edges
	task automatic frame(input logic [12:0] word, input int nFalls);
		chipSelN = 1'b0;
		for (int i = 0; i < nFalls; i++) begin
			serialIn = (i < 13) ? word[12 - i] : ~serialIn;
			#62.5 serialClk = 1'b1;
			#62.5 serialClk = 1'b0;
		end
		// Released data line shows no stale value
		#62.5 serialIn = ~serialIn;
	endtask
	task automatic release_cs();
		#62.5 chipSelN = 1'b1;
	endtask
endmodule

//--- tb/tb_adc_mux_speed_config_decoder.sv
// Testbench for the configuration word decoder
module tb_adc_mux_speed_config_decoder;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, convEnd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic serialClk, serialIn, chipSelN, e;
	logic resultStrobe, resultValid, mixedNoise, offsetCancel, runningAverage;
	logic [3:0] muxPos, muxNeg;
	logic [2:0] refSel;
	logic [15:0] oversamplingRatio, r;
	logic rateDoublerSelect;
	int bad_count, n_compared;
	amsc_link_host host (.serialClk(serialClk), .serialIn(serialIn), .chipSelN(chipSelN));
	amsc_decoder DUT (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serialClk(serialClk), .serialIn(serialIn), .chipSelN(chipSelN),
		.convEnd(convEnd), .resultStrobe(resultStrobe), .resultValid(resultValid),
		.mixedNoise(mixedNoise), .offsetCancel(offsetCancel), .runningAverage(runningAverage),
		.muxPos(muxPos), .muxNeg(muxNeg), .refSel(refSel),
		.oversamplingRatio(oversamplingRatio), .rateDoublerSelect(rateDoublerSelect));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic end_sim();
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hung access
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check(pready, 1'b1);
	endtask
	task automatic cfg(input logic [2:0] h, input logic [4:0] c, input logic [4:0] s);
		host.frame({h, c, s}, 14);
		host.release_cs();
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic check_sel(input logic [4:0] c);
		logic [3:0] p;
		p = {1'b0, c[1:0], c[3]};
		check(muxPos, p);
		check(muxNeg, c[4] ? 4'h8 : {p[3:1], ~p[0]});
		check(refSel, c[2] ? 3'h4 : {1'b0, c[1:0]});
	endtask
	task automatic conv(input logic v, input logic m);
		@(posedge ref_clk) convEnd <= 1'b1;
		@(posedge ref_clk) convEnd <= 1'b0;
		#1;
		check(resultStrobe, 1'b1);
		check(resultValid, v);
		check(mixedNoise, m);
	endtask
	initial begin
		#800us;
		bad_count++;
		end_sim();
	end
	initial begin
		bad_count = 0;
		n_compared = 0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		convEnd = 1'b0;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		#1;
		check(oversamplingRatio, 16'h0100);
		check(rateDoublerSelect, 1'b0);
		check_sel(5'h00);
		apb(1'b0, 12'h004, 32'h00000000);
		check(d[10:0], 11'h060);
		apb(1'b0, 12'h000, 32'h00000000);
		check(d, 32'h00000001);
		apb(1'b0, 12'h00C, 32'h00000000);
		check(e, 1'b1);
		// Link disabled: frame has no effect
		apb(1'b1, 12'h000, 32'h00000000);
		cfg(3'h5, 5'h13, 5'h00);
		check_sel(5'h00);
		apb(1'b1, 12'h000, 32'h00000001);
		for (int c = 0; c < 32; c++) begin
			cfg(3'h5, c[4:0], 5'h01);
			check_sel(c[4:0]);
			check(oversamplingRatio, 16'h0100);
			check(rateDoublerSelect, 1'b0);
		end
		r = 16'h0100;
		for (int s = 1; s < 16; s++) begin
			cfg(3'h5, 5'h00, {s[3:0], 1'b0});
			if (s < 10) r = 16'h0040 << (s - 1);
			if (s == 15) r = 16'h8000;
			check(oversamplingRatio, r);
		end
		cfg(3'h0, 5'h1F, 5'h03);
		check_sel(5'h00);
		cfg(3'h4, 5'h1F, 5'h03);
		check_sel(5'h00);
		check(oversamplingRatio, 16'h8000);
		// Frame cut at 13 falling edges is dropped
		host.frame({3'h5, 5'h05, 5'h00}, 13);
		repeat (8) @(posedge ref_clk);
		check_sel(5'h00);
		host.release_cs();
		repeat (6) @(posedge ref_clk);
		check_sel(5'h00);
		host.frame({3'h5, 5'h05, 5'h00}, 14);
		repeat (8) @(posedge ref_clk);
		check_sel(5'h05);
		host.release_cs();
		repeat (6) @(posedge ref_clk);
		conv(1'b1, 1'b0);
		check(offsetCancel, 1'b1);
		check(runningAverage, 1'b0);
		cfg(3'h5, 5'h05, 5'h1F);
		check(rateDoublerSelect, 1'b1);
		check(runningAverage, 1'b1);
		check(offsetCancel, 1'b0);
		conv(1'b1, 1'b0);
		cfg(3'h5, 5'h1A, 5'h00);
		check_sel(5'h05);
		conv(1'b0, 1'b0);
		check_sel(5'h1A);
		conv(1'b1, 1'b0);
		cfg(3'h5, 5'h1A, 5'h09);
		check(oversamplingRatio, 16'h0200);
		conv(1'b1, 1'b1);
		conv(1'b1, 1'b0);
		end_sim();
	end
endmodule
